// *** rtl/ultlpm_defines.vh ***
// register map, field positions, reset values and encodings for the latency/lpm block
`ifndef ULTLPM_DEFINES_VH
`define ULTLPM_DEFINES_VH

// register byte offsets
`define ULTLPM_CFG0_OFS 8'h00
`define ULTLPM_CFG1_OFS 8'h04
`define ULTLPM_QTOL_A_OFS 8'h08
`define ULTLPM_QTOL_B_OFS 8'h0C
`define ULTLPM_BTOL_A_OFS 8'h10
`define ULTLPM_BTOL_B_OFS 8'h14
`define ULTLPM_RLD_A_OFS 8'h18
`define ULTLPM_RLD_B_OFS 8'h1C
`define ULTLPM_PMT_OFS 8'h20
`define ULTLPM_STAT_OFS 8'h24

// field positions
`define ULTLPM_CFG0_RWAKE_BIT 0
`define ULTLPM_CFG0_LPM_BIT 1
`define ULTLPM_CFG1_LTM_BIT 0
`define ULTLPM_LO_FIELD_LSB 0
`define ULTLPM_HI_FIELD_LSB 16

// reset values
`define ULTLPM_CFG0_RST 2'h0
`define ULTLPM_CFG1_RST 1'h0
`define ULTLPM_TOL_RST 12'h000
`define ULTLPM_RLD_RST 16'h00FF
`define ULTLPM_PMT_RST 2'h0

// ethernet speed codes
`define ULTLPM_SPD_10 2'h0
`define ULTLPM_SPD_100 2'h1
`define ULTLPM_SPD_1000 2'h2

// link state codes
`define ULTLPM_LINK_U0 2'h0
`define ULTLPM_LPM_L1 2'h1
`define ULTLPM_LPM_L2 2'h2

// device descriptor constants
`define ULTLPM_DD_LEN 8'h12
`define ULTLPM_DD_TYPE 8'h01
`define ULTLPM_BCD_USB2 16'h0210
`define ULTLPM_BCD_USB3 16'h0300
`define ULTLPM_EP0_SS 8'h09
`define ULTLPM_EP0_HS 8'h40
`define ULTLPM_REL_LSB 8'h00

`endif

// *** rtl/ultlpm_speed_sel.v ***
// picks one of three per-speed values from the ethernet link speed
`timescale 1ns/1ns
`include "ultlpm_defines.vh"
module ultlpm_speed_sel #(
  parameter W = 12
) (
  // link status
  input wire [1:0] ethSpeed,
  input wire ethLinkUp,
  // per-speed values
  input wire [W-1:0] valGig,
  input wire [W-1:0] valFast,
  input wire [W-1:0] valSlow,
  // chosen value
  output wire [W-1:0] selVal
);

  function [W-1:0] pick;
    input [1:0] spd;
    input up;
    input [W-1:0] g;
    input [W-1:0] f;
    input [W-1:0] s;
    begin
      // no link falls back to the gigabit field
      if (!up || spd == `ULTLPM_SPD_1000) pick = g;
      else if (spd == `ULTLPM_SPD_100) pick = f;
      else pick = s;
    end
  endfunction

  assign selVal = pick(ethSpeed, ethLinkUp, valGig, valFast, valSlow);

endmodule // ultlpm_speed_sel

// *** rtl/ultlpm_desc_rom.v ***
// device descriptor byte source with defaults and hardware overwrites
`timescale 1ns/1ns
`include "ultlpm_defines.vh"
module ultlpm_desc_rom #(
  parameter [7:0] SI_RELEASE = 8'h0A, // arbitrary release code
  parameter [15:0] VENDOR_CODE = 16'h1234, // arbitrary vendor code
  parameter [15:0] PRODUCT_CODE = 16'h5678 // arbitrary product code
) (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  input wire clkEn,
  // source selection
  input wire otpValid,
  input wire eepromValid,
  input wire customMode,
  input wire superSpeed,
  // byte lookup
  input wire [4:0] descIndex,
  input wire [7:0] storedByte,
  input wire [7:0] customByte,
  output reg [7:0] descByte
);

  function [7:0] defByte;
    input [4:0] idx;
    input ss;
    reg [15:0] bcd;
    begin
      bcd = ss ? `ULTLPM_BCD_USB3 : `ULTLPM_BCD_USB2;
      case (idx)
        5'h02: defByte = bcd[7:0];
        5'h03: defByte = bcd[15:8];
        5'h04: defByte = 8'hFF;
        5'h06: defByte = 8'hFF;
        5'h07: defByte = ss ? `ULTLPM_EP0_SS : `ULTLPM_EP0_HS;
        5'h08: defByte = VENDOR_CODE[7:0];
        5'h09: defByte = VENDOR_CODE[15:8];
        5'h0A: defByte = PRODUCT_CODE[7:0];
        5'h0B: defByte = PRODUCT_CODE[15:8];
        5'h0D: defByte = SI_RELEASE;
        5'h11: defByte = 8'h01;
        default: defByte = 8'h00;
      endcase
    end
  endfunction

  reg [7:0] next_descByte;

  always @* begin
    if (otpValid || eepromValid) next_descByte = storedByte;
    else if (customMode) next_descByte = customByte;
    else next_descByte = defByte(descIndex, superSpeed);
    // length, type and release low byte are never taken from storage
    if (descIndex == 5'h00) next_descByte = `ULTLPM_DD_LEN;
    if (descIndex == 5'h01) next_descByte = `ULTLPM_DD_TYPE;
    if (descIndex == 5'h0C) next_descByte = `ULTLPM_REL_LSB;
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) descByte <= 8'h00;
    else if (clkEn) descByte <= next_descByte;
  end

endmodule // ultlpm_desc_rom

// *** rtl/ultlpm_top.v ***
// latency tolerance messaging, remote wakeup and link power control with ahb-lite registers
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`include "ultlpm_defines.vh"
module ultlpm_top #(
  parameter BELT_W = 12,
  parameter TMR_W = 16,
  parameter [7:0] SI_RELEASE = 8'h0A // arbitrary release code
) (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  input wire clkEn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // configuration load from otp or eeprom
  input wire cfgLoadStrobe,
  input wire cfgLtmEnableLoad,
  // host features and remote wakeup
  input wire hsfsMode,
  input wire hostRemoteWakeFeature,
  input wire hostLtmFeature,
  input wire wakeEvent,
  output reg remoteWakeSignal,
  // traffic status
  input wire usbTxEmpty,
  input wire usbRxEmpty,
  input wire ethTxEmpty,
  input wire ethRxEmpty,
  input wire epPacketPending,
  input wire ethFrameRx,
  input wire hostPacketsPending,
  // ethernet link
  input wire ethLinkUp,
  input wire [1:0] ethSpeed,
  // usb link states
  input wire [1:0] usbLinkState,
  input wire [3:0] epIdleOrFlow,
  output reg linkToU0Req,
  output reg uxTransitionAllowed,
  // link power management
  input wire lpmRequest,
  input wire [1:0] lpmLinkState,
  input wire ethFrameFiltered,
  input wire intEpScheduled,
  output reg lpmAdvertise,
  output reg lpmAccept,
  output reg l1ExitReq,
  output reg [1:0] suspendDepth,
  // latency message
  input wire ltmReady,
  output wire ltmValid,
  output reg [BELT_W-1:0] ltmBelt,
  output reg latencyBusy,
  // descriptor
  input wire otpValid,
  input wire eepromValid,
  input wire customMode,
  input wire superSpeed,
  input wire [4:0] descIndex,
  input wire [7:0] storedByte,
  input wire [7:0] customByte,
  output wire [7:0] descByte
);

  localparam QUIET = 1'b0;
  localparam BUSY = 1'b1;

  // registers
  reg [1:0] usb_config_reg_zero;
  reg usb_config_reg_one;
  reg [BELT_W-1:0] quiet_tolerance_gig;
  reg [BELT_W-1:0] quiet_tolerance_fast;
  reg [BELT_W-1:0] quiet_tolerance_slow;
  reg [BELT_W-1:0] busy_tolerance_gig;
  reg [BELT_W-1:0] busy_tolerance_fast;
  reg [BELT_W-1:0] busy_tolerance_slow;
  reg [TMR_W-1:0] idle_reload_gig;
  reg [TMR_W-1:0] idle_reload_fast;
  reg [TMR_W-1:0] idle_reload_slow;
  reg [1:0] power_mgmt_control_reg;

  // bus and state
  reg wrPend;
  reg [7:0] wrAddr;
  reg state;
  reg [TMR_W-1:0] quiet_entry_countdown;
  reg cntRun;
  reg quietSent;
  reg msgPending;
  reg ltmFeatPrev;

  reg next_state;
  reg [TMR_W-1:0] next_cnt;
  reg next_cntRun;
  reg next_quietSent;
  reg queueMsg;
  reg enterBusy;

  wire [BELT_W-1:0] quietBelt;
  wire [BELT_W-1:0] busyBelt;
  wire [TMR_W-1:0] reloadVal;
  wire addrPhase;
  wire fifosEmpty;
  wire trafficHalt;
  wire busyTrigger;
  wire sendEn;
  wire msgTaken;

  ultlpm_speed_sel #(.W(BELT_W)) uQuietSel (
    .ethSpeed(ethSpeed),
    .ethLinkUp(ethLinkUp),
    .valGig(quiet_tolerance_gig),
    .valFast(quiet_tolerance_fast),
    .valSlow(quiet_tolerance_slow),
    .selVal(quietBelt)
  );

  ultlpm_speed_sel #(.W(BELT_W)) uBusySel (
    .ethSpeed(ethSpeed),
    .ethLinkUp(ethLinkUp),
    .valGig(busy_tolerance_gig),
    .valFast(busy_tolerance_fast),
    .valSlow(busy_tolerance_slow),
    .selVal(busyBelt)
  );

  ultlpm_speed_sel #(.W(TMR_W)) uReloadSel (
    .ethSpeed(ethSpeed),
    .ethLinkUp(ethLinkUp),
    .valGig(idle_reload_gig),
    .valFast(idle_reload_fast),
    .valSlow(idle_reload_slow),
    .selVal(reloadVal)
  );

  ultlpm_desc_rom #(.SI_RELEASE(SI_RELEASE)) uDesc (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .otpValid(otpValid),
    .eepromValid(eepromValid),
    .customMode(customMode),
    .superSpeed(superSpeed),
    .descIndex(descIndex),
    .storedByte(storedByte),
    .customByte(customByte),
    .descByte(descByte)
  );

  // bus slave: zero wait states; stalls only while the clock enable is low
  assign hreadyout = clkEn;
  assign hresp = 1'b0;
  assign addrPhase = hsel && hready && htrans[1] && hsize == 3'h2;

  function [31:0] readReg;
    input [7:0] a;
    begin
      case (a)
        `ULTLPM_CFG0_OFS: readReg = {30'h0, usb_config_reg_zero};
        `ULTLPM_CFG1_OFS: readReg = {31'h0, usb_config_reg_one};
        `ULTLPM_QTOL_A_OFS: readReg = {4'h0, quiet_tolerance_fast, 4'h0, quiet_tolerance_gig};
        `ULTLPM_QTOL_B_OFS: readReg = {20'h0, quiet_tolerance_slow};
        `ULTLPM_BTOL_A_OFS: readReg = {4'h0, busy_tolerance_fast, 4'h0, busy_tolerance_gig};
        `ULTLPM_BTOL_B_OFS: readReg = {20'h0, busy_tolerance_slow};
        `ULTLPM_RLD_A_OFS: readReg = {idle_reload_fast, idle_reload_gig};
        `ULTLPM_RLD_B_OFS: readReg = {16'h0, idle_reload_slow};
        `ULTLPM_PMT_OFS: readReg = {30'h0, power_mgmt_control_reg};
        `ULTLPM_STAT_OFS: readReg = {quiet_entry_countdown, 11'h0, ethLinkUp, ethSpeed,
          msgPending, state};
        default: readReg = 32'h0000_0000;
      endcase
    end
  endfunction

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (clkEn) begin
      wrPend <= addrPhase && hwrite;
      wrAddr <= haddr[7:0];
      if (addrPhase && !hwrite) hrdata <= readReg(haddr[7:0]);
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      usb_config_reg_zero <= `ULTLPM_CFG0_RST;
      usb_config_reg_one <= `ULTLPM_CFG1_RST;
      quiet_tolerance_gig <= `ULTLPM_TOL_RST;
      quiet_tolerance_fast <= `ULTLPM_TOL_RST;
      quiet_tolerance_slow <= `ULTLPM_TOL_RST;
      busy_tolerance_gig <= `ULTLPM_TOL_RST;
      busy_tolerance_fast <= `ULTLPM_TOL_RST;
      busy_tolerance_slow <= `ULTLPM_TOL_RST;
      idle_reload_gig <= `ULTLPM_RLD_RST;
      idle_reload_fast <= `ULTLPM_RLD_RST;
      idle_reload_slow <= `ULTLPM_RLD_RST;
      power_mgmt_control_reg <= `ULTLPM_PMT_RST;
    end else if (clkEn) begin
      // storage loader sets the enable default after reset; software may override later
      if (cfgLoadStrobe) usb_config_reg_one <= cfgLtmEnableLoad;
      if (wrPend) begin
        case (wrAddr)
          `ULTLPM_CFG0_OFS: usb_config_reg_zero <= hwdata[1:0];
          `ULTLPM_CFG1_OFS: usb_config_reg_one <= hwdata[`ULTLPM_CFG1_LTM_BIT];
          `ULTLPM_QTOL_A_OFS: begin
            quiet_tolerance_gig <= hwdata[`ULTLPM_LO_FIELD_LSB +: BELT_W];
            quiet_tolerance_fast <= hwdata[`ULTLPM_HI_FIELD_LSB +: BELT_W];
          end
          `ULTLPM_QTOL_B_OFS: quiet_tolerance_slow <= hwdata[`ULTLPM_LO_FIELD_LSB +: BELT_W];
          `ULTLPM_BTOL_A_OFS: begin
            busy_tolerance_gig <= hwdata[`ULTLPM_LO_FIELD_LSB +: BELT_W];
            busy_tolerance_fast <= hwdata[`ULTLPM_HI_FIELD_LSB +: BELT_W];
          end
          `ULTLPM_BTOL_B_OFS: busy_tolerance_slow <= hwdata[`ULTLPM_LO_FIELD_LSB +: BELT_W];
          `ULTLPM_RLD_A_OFS: begin
            idle_reload_gig <= hwdata[`ULTLPM_LO_FIELD_LSB +: TMR_W];
            idle_reload_fast <= hwdata[`ULTLPM_HI_FIELD_LSB +: TMR_W];
          end
          `ULTLPM_RLD_B_OFS: idle_reload_slow <= hwdata[`ULTLPM_LO_FIELD_LSB +: TMR_W];
          `ULTLPM_PMT_OFS: power_mgmt_control_reg <= hwdata[1:0];
          default: ;
        endcase
      end
    end
  end

  // traffic classification
  assign fifosEmpty = usbTxEmpty && usbRxEmpty && ethTxEmpty && ethRxEmpty;
  assign trafficHalt = fifosEmpty && !epPacketPending && !ethFrameRx
    && !hostPacketsPending;
  assign busyTrigger = !fifosEmpty || ethFrameRx || hostPacketsPending;

  always @* begin
    next_state = state;
    next_cnt = quiet_entry_countdown;
    next_cntRun = cntRun;
    next_quietSent = quietSent;
    queueMsg = 1'b0;
    enterBusy = 1'b0;
    case (state)
      QUIET: begin
        if (ethLinkUp && busyTrigger) begin
          next_state = BUSY;
          next_cntRun = 1'b0;
          next_quietSent = 1'b0;
          queueMsg = 1'b1;
          enterBusy = 1'b1;
        end else if (!trafficHalt || quietSent) begin
          next_cntRun = 1'b0;
        end else if (!cntRun) begin
          next_cnt = reloadVal;
          next_cntRun = 1'b1;
        end else if (quiet_entry_countdown == {TMR_W{1'b0}}) begin
          next_cntRun = 1'b0;
          next_quietSent = 1'b1;
          queueMsg = 1'b1;
        end else begin
          next_cnt = quiet_entry_countdown - 1'b1;
        end
      end
      BUSY: begin
        if (!ethLinkUp) begin
          // losing the link forces quiet at once
          next_state = QUIET;
          next_cntRun = 1'b0;
          next_quietSent = 1'b1;
          queueMsg = 1'b1;
        end else if (!trafficHalt) begin
          next_cntRun = 1'b0;
        end else if (!cntRun) begin
          next_cnt = reloadVal;
          next_cntRun = 1'b1;
        end else if (quiet_entry_countdown == {TMR_W{1'b0}}) begin
          next_state = QUIET;
          next_cntRun = 1'b0;
          next_quietSent = 1'b1;
          queueMsg = 1'b1;
        end else begin
          next_cnt = quiet_entry_countdown - 1'b1;
        end
      end
      default: begin
        next_state = QUIET;
        next_cntRun = 1'b0;
      end
    endcase
  end

  // a message leaves only with both enables; otherwise it is dropped silently
  assign sendEn = usb_config_reg_one && hostLtmFeature;
  assign ltmValid = msgPending && sendEn;
  assign msgTaken = ltmValid && ltmReady;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= QUIET;
      quiet_entry_countdown <= {TMR_W{1'b0}};
      cntRun <= 1'b0;
      quietSent <= 1'b0;
      msgPending <= 1'b0;
      ltmBelt <= {BELT_W{1'b0}};
      ltmFeatPrev <= 1'b0;
      latencyBusy <= 1'b0;
      linkToU0Req <= 1'b0;
    end else if (clkEn) begin
      state <= next_state;
      quiet_entry_countdown <= next_cnt;
      cntRun <= next_cntRun;
      quietSent <= next_quietSent;
      latencyBusy <= next_state;
      ltmFeatPrev <= hostLtmFeature;
      linkToU0Req <= enterBusy && usbLinkState != `ULTLPM_LINK_U0;
      // a new event wins over the hand-off of the previous one
      if (queueMsg || (hostLtmFeature && !ltmFeatPrev)) begin
        msgPending <= sendEn || (hostLtmFeature && !ltmFeatPrev && usb_config_reg_one);
        ltmBelt <= next_state ? busyBelt : quietBelt;
      end else if (msgTaken || !sendEn) begin
        msgPending <= 1'b0;
      end
    end
  end

  // wakeup, link state and lpm outputs
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      remoteWakeSignal <= 1'b0;
      uxTransitionAllowed <= 1'b0;
      lpmAdvertise <= 1'b0;
      lpmAccept <= 1'b0;
      l1ExitReq <= 1'b0;
      suspendDepth <= 2'h0;
    end else if (clkEn) begin
      remoteWakeSignal <= wakeEvent && hsfsMode && hostRemoteWakeFeature
        && usb_config_reg_zero[`ULTLPM_CFG0_RWAKE_BIT];
      uxTransitionAllowed <= &epIdleOrFlow;
      lpmAdvertise <= usb_config_reg_zero[`ULTLPM_CFG0_LPM_BIT];
      lpmAccept <= lpmRequest && usb_config_reg_zero[`ULTLPM_CFG0_LPM_BIT];
      l1ExitReq <= usb_config_reg_zero[`ULTLPM_CFG0_LPM_BIT]
        && lpmLinkState == `ULTLPM_LPM_L1 && (ethFrameFiltered || intEpScheduled);
      suspendDepth <= (lpmLinkState == `ULTLPM_LPM_L2) ? power_mgmt_control_reg : 2'h0;
    end
  end

endmodule // ultlpm_top

// *** verification/ultlpm_props.sv ***
// concurrent checks on the latency, lpm and descriptor ports
`timescale 1ns/1ns
module ultlpm_props (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  input wire clkEn,
  // bus and wakeup
  input wire hresp,
  input wire hsfsMode,
  input wire hostRemoteWakeFeature,
  input wire wakeEvent,
  input wire remoteWakeSignal,
  // latency state
  input wire hostLtmFeature,
  input wire ltmValid,
  input wire latencyBusy,
  input wire ethLinkUp,
  input wire ethFrameRx,
  input wire hostPacketsPending,
  input wire usbTxEmpty,
  input wire usbRxEmpty,
  input wire ethTxEmpty,
  input wire ethRxEmpty,
  // link states
  input wire [1:0] usbLinkState,
  input wire linkToU0Req,
  input wire [3:0] epIdleOrFlow,
  input wire uxTransitionAllowed,
  input wire lpmRequest,
  input wire lpmAccept,
  input wire lpmAdvertise,
  input wire l1ExitReq,
  input wire [1:0] lpmLinkState,
  input wire ethFrameFiltered,
  input wire intEpScheduled,
  input wire [1:0] suspendDepth,
  // descriptor
  input wire [4:0] descIndex,
  input wire [7:0] descByte
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_trigger;
    ethLinkUp && (ethFrameRx || hostPacketsPending || !(usbTxEmpty && usbRxEmpty && ethTxEmpty && ethRxEmpty));
  endsequence
  sequence s_no_link;
    !ethLinkUp ##1 !ethLinkUp;
  endsequence
  property p_wake;
    remoteWakeSignal && $past(hsfsMode) |-> $past(hostRemoteWakeFeature) && $past(wakeEvent);
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup without host feature");
  property p_busy;
    !latencyBusy ##0 s_trigger |=> latencyBusy;
  endproperty
  a_busy: assert property (p_busy) else $error("traffic did not enter busy");
  property p_quiet;
    s_no_link |-> !latencyBusy;
  endproperty
  a_quiet: assert property (p_quiet) else $error("busy without link");
  property p_gate;
    ltmValid |-> hostLtmFeature;
  endproperty
  a_gate: assert property (p_gate) else $error("message without host feature");
  property p_u0;
    linkToU0Req == ($rose(latencyBusy) && $past(usbLinkState) != 2'h0);
  endproperty
  a_u0: assert property (p_u0) else $error("u0 return request wrong");
  property p_ux;
    // both directions; a frozen or just-reset flop has nothing to follow
    $past(arst_n) && $past(clkEn) |-> uxTransitionAllowed == &$past(epIdleOrFlow);
  endproperty
  a_ux: assert property (p_ux) else $error("u1/u2 allowed with busy endpoint");
  property p_accept;
    lpmAccept |-> lpmAdvertise && $past(lpmRequest);
  endproperty
  a_accept: assert property (p_accept) else $error("lpm accepted without capability");
  property p_l1;
    l1ExitReq |-> lpmAdvertise && $past(lpmLinkState) == 2'h1
      && ($past(ethFrameFiltered) || $past(intEpScheduled));
  endproperty
  a_l1: assert property (p_l1) else $error("l1 exit without cause");
  property p_susp;
    lpmLinkState != 2'h2 |=> suspendDepth == 2'h0;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend depth outside l2");
  property p_len;
    descIndex == 5'h00 |=> descByte == 8'h12;
  endproperty
  a_len: assert property (p_len) else $error("length byte wrong");
  property p_rel;
    descIndex == 5'h0C |=> descByte == 8'h00;
  endproperty
  a_rel: assert property (p_rel) else $error("release low byte wrong");
  property p_resp;
    hresp == 1'b0;
  endproperty
  a_resp: assert property (p_resp) else $error("bus response not okay");
endmodule // ultlpm_props
bind ultlpm_top ultlpm_props ultlpm_props_inst (.*);

// *** verification/ultlpm_host_model.sv ***
// host-side model: owns the ltm feature and consumes latency messages
`timescale 1ns/1ns
module ultlpm_host_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // feature control and pacing
  input wire logic ltmOn,
  input wire logic stall,
  // message channel
  input wire logic ltmValid,
  input wire logic [11:0] ltmBelt,
  output logic ltmReady,
  output logic hostLtmFeature,
  output logic taken,
  output logic [11:0] takenBelt
);
  // a slow host just holds ready low; the message must stand meanwhile
  assign ltmReady = arst_n & ~stall;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hostLtmFeature <= 1'b0;
      taken <= 1'b0;
      takenBelt <= 12'h000;
    end else begin
      hostLtmFeature <= ltmOn;
      taken <= ltmValid & ltmReady;
      takenBelt <= ltmBelt;
    end
  end
endmodule // ultlpm_host_model

// *** verification/test_usb_latency_tolerance_and_lpm_control.sv ***
// self-checking bench for the latency, lpm and descriptor block
`timescale 1ns/1ns
module test_usb_latency_tolerance_and_lpm_control;
  localparam logic [7:0] REL = 8'h0A; // arbitrary release code
  logic core_clk, arst_n, clkEn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv, rnd;
  logic [1:0] htrans, ethSpeed, usbLinkState, lpmLinkState, suspendDepth;
  logic [2:0] hsize;
  logic cfgLoadStrobe, cfgLtmEnableLoad, hsfsMode, hostRemoteWakeFeature, wakeEvent;
  logic usbTxEmpty, usbRxEmpty, ethTxEmpty, ethRxEmpty, epPacketPending, ethFrameRx;
  logic hostPacketsPending, ethLinkUp, linkToU0Req, uxTransitionAllowed, lpmRequest;
  logic ethFrameFiltered, intEpScheduled, lpmAdvertise, lpmAccept, l1ExitReq, remoteWakeSignal;
  logic ltmReady, ltmValid, latencyBusy, otpValid, eepromValid, customMode, superSpeed;
  logic hostLtmFeature, stall, slowHost, ltmOn, taken;
  logic [3:0] epIdleOrFlow;
  logic [4:0] descIndex;
  logic [7:0] storedByte, customByte, descByte;
  logic [11:0] ltmBelt, takenBelt, wexp;
  logic [11:0] qv[3], bv[3], expQ[$];
  logic [15:0] rl[3];
  int n_errors, checks, seed;
  wire hready = hreadyout;
  ultlpm_top #(.SI_RELEASE(REL)) ultlpm_top_inst (.*);
  ultlpm_host_model ultlpm_host_model_inst (.*);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // one single-word transfer; waits on hready, never on a fixed count
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  task drain;
    repeat (200) if (expQ.size() != 0) @(posedge core_clk);
  endtask
  task setTrig(input int t, input logic on);
    case (t)
      0: usbTxEmpty <= !on;
      1: usbRxEmpty <= !on;
      2: ethTxEmpty <= !on;
      3: ethRxEmpty <= !on;
      4: ethFrameRx <= on;
      default: hostPacketsPending <= on;
    endcase
  endtask
  task desc(input logic [1:0] src, input logic ss, input logic [4:0] i, input logic [7:0] e);
    otpValid <= src == 2'h1;
    eepromValid <= src == 2'h2;
    customMode <= src == 2'h3;
    superSpeed <= ss;
    descIndex <= i;
    cyc(2);
    chk(descByte, e);
  endtask
  // every message the host takes must match the oldest noted value
  always @(posedge core_clk) begin
    if (taken === 1'b1) begin
      wexp = (expQ.size() != 0) ? expQ.pop_front() : ~takenBelt;
      chk(takenBelt, wexp);
    end
  end
  always @(posedge core_clk) begin
    rnd = $random(seed);
    stall <= slowHost & rnd[0];
    epIdleOrFlow <= rnd[4:1];
    usbLinkState <= rnd[6:5];
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    summarize();
  end
  initial begin
    seed = 32'h07d2;
    {clkEn, usbTxEmpty, usbRxEmpty, ethTxEmpty, ethRxEmpty} = 5'h1F;
    {hsel, hwrite, cfgLoadStrobe, cfgLtmEnableLoad, hsfsMode, hostRemoteWakeFeature} = '0;
    {wakeEvent, epPacketPending, ethFrameRx, hostPacketsPending, ethLinkUp, lpmRequest} = '0;
    {ethFrameFiltered, intEpScheduled, otpValid, eepromValid, customMode, superSpeed} = '0;
    {slowHost, ltmOn, haddr, hwdata, htrans, ethSpeed, lpmLinkState} = '0;
    {descIndex, storedByte, customByte} = '0;
    hsize = 3'h2;
    arst_n = 1'b0;
    cyc(16);
    arst_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h18, 32'h00FF_00FF);
    rd(8'h1C, 32'h0000_00FF);
    rd(8'h40, 32'h0);
    hsfsMode <= 1'b1;
    hostRemoteWakeFeature <= 1'b1;
    wakeEvent <= 1'b1;
    lpmRequest <= 1'b1;
    ethLinkUp <= 1'b1;
    ethSpeed <= 2'h2;
    ltmOn <= 1'b1;
    cyc(10);
    chk(remoteWakeSignal, 1'b0);
    chk(lpmAccept, 1'b0);
    chk(ltmValid, 1'b0);
    ltmOn <= 1'b0;
    cfgLtmEnableLoad <= 1'b1;
    cfgLoadStrobe <= 1'b1;
    cyc(1);
    cfgLoadStrobe <= 1'b0;
    rd(8'h04, 32'h0000_0001);
    for (int k = 0; k < 3; k++) begin
      qv[k] = 12'($random(seed));
      bv[k] = 12'($random(seed));
      rl[k] = 16'(3 + k);
    end
    bus(1'b1, 8'h08, {4'h0, qv[1], 4'h0, qv[2]});
    bus(1'b1, 8'h0C, {20'h0_0000, qv[0]});
    bus(1'b1, 8'h10, {4'h0, bv[1], 4'h0, bv[2]});
    bus(1'b1, 8'h14, {20'h0_0000, bv[0]});
    bus(1'b1, 8'h18, {rl[1], rl[2]});
    bus(1'b1, 8'h1C, {16'h0000, rl[0]});
    bus(1'b1, 8'h20, 32'h0000_0002);
    bus(1'b1, 8'h00, 32'h0000_0003);
    rd(8'h10, {4'h0, bv[1], 4'h0, bv[2]});
    cyc(1);
    chk(remoteWakeSignal, 1'b1);
    chk(lpmAccept, 1'b1);
    hostRemoteWakeFeature <= 1'b0;
    lpmLinkState <= 2'h1;
    ethFrameFiltered <= 1'b1;
    cyc(2);
    chk(remoteWakeSignal, 1'b0);
    chk(l1ExitReq, 1'b1);
    ethFrameFiltered <= 1'b0;
    intEpScheduled <= 1'b1;
    cyc(2);
    chk(l1ExitReq, 1'b1);
    intEpScheduled <= 1'b0;
    lpmLinkState <= 2'h2;
    cyc(2);
    chk(suspendDepth, 2'h2);
    lpmLinkState <= 2'h0;
    ethLinkUp <= 1'b0;
    cyc(20);
    expQ.push_back(qv[2]);
    ltmOn <= 1'b1;
    drain();
    hostPacketsPending <= 1'b1;
    cyc(4);
    chk(latencyBusy, 1'b0);
    hostPacketsPending <= 1'b0;
    ltmOn <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      for (int t = 0; t < 6; t++) begin
        ethSpeed <= 2'(s);
        ethLinkUp <= 1'b1;
        slowHost <= t[0];
        cyc(20);
        expQ.push_back(qv[s]);
        ltmOn <= 1'b1;
        drain();
        expQ.push_back(bv[s]);
        setTrig(t, 1'b1);
        drain();
        setTrig(t, 1'b0);
        cyc(2);
        setTrig(t, 1'b1);
        cyc(1);
        setTrig(t, 1'b0);
        for (int n = 0; n < rl[s]; n++) begin
          @(posedge core_clk);
          chk({ltmValid, latencyBusy}, 2'b01);
        end
        expQ.push_back(qv[s]);
        drain();
        ltmOn <= 1'b0;
      end
    end
    storedByte <= 8'($random(seed));
    customByte <= 8'($random(seed));
    cyc(1);
    desc(2'h1, 1'b0, 5'h00, 8'h12);
    desc(2'h2, 1'b0, 5'h01, 8'h01);
    desc(2'h1, 1'b0, 5'h04, storedByte);
    desc(2'h2, 1'b1, 5'h05, storedByte);
    desc(2'h3, 1'b0, 5'h04, customByte);
    desc(2'h0, 1'b0, 5'h02, 8'h10);
    desc(2'h0, 1'b0, 5'h03, 8'h02);
    desc(2'h0, 1'b1, 5'h02, 8'h00);
    desc(2'h0, 1'b1, 5'h03, 8'h03);
    desc(2'h0, 1'b1, 5'h07, 8'h09);
    desc(2'h0, 1'b0, 5'h07, 8'h40);
    desc(2'h1, 1'b0, 5'h0C, 8'h00);
    desc(2'h0, 1'b0, 5'h0D, REL);
    // enable low: bus must wait and descriptor byte must hold
    clkEn <= 1'b0;
    descIndex <= 5'h07;
    fork
      rd(8'h04, 32'h0000_0001);
      begin
        cyc(3);
        chk(descByte, REL);
        clkEn <= 1'b1;
      end
    join
    chk(expQ.size(), 32'h0);
    summarize();
  end
endmodule // test_usb_latency_tolerance_and_lpm_control
